//--- rtl/qrs_defs.svh
// Constants for the burst static memory port logic
`ifndef QRS_DEFS_SVH
`define QRS_DEFS_SVH
`define QRS_DW 18
`define QRS_AW 19
`define QRS_LW 9
`define QRS_BW 72
`define QRS_BL 8
`define QRS_IMP_CYC 1024
`define QRS_IMP_W 10
`define QRS_LOCK_CYC 2048
`define QRS_LOCK_W 12
`define QRS_SYS_NS 40
`define QRS_STOP_NS 30
`define QRS_STOP_CYC ((`QRS_STOP_NS + `QRS_SYS_NS - 1) / `QRS_SYS_NS)
`define QRS_STOP_GUARD 3
`define QRS_STOP_W 3
`endif

//--- rtl/qrs_pkg.sv
// Types for the burst static memory port logic
package qrs_pkg;
  typedef enum logic [2:0] {
    QRS_OUT_IDLE = 3'h1,
    QRS_OUT_FIRST = 3'h2,
    QRS_OUT_SECOND = 3'h4
  } qrs_out_type;
endpackage

//--- rtl/qrs_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module qrs_sync2 (
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule
`default_nettype wire

//--- rtl/qrs_mem_array.sv
// Burst-wide storage array with lane write enables
`timescale 1ns/100ps
`default_nettype none
`include "qrs_defs.svh"
module qrs_mem_array (
  input wire logic clk,
  input wire logic we,
  input wire logic [`QRS_AW-1:0] waddr,
  input wire logic [`QRS_BW-1:0] wdata,
  input wire logic [`QRS_BL-1:0] wlane,
  input wire logic [`QRS_AW-1:0] raddr,
  output logic [`QRS_BW-1:0] rdata
);
  // One array per lane so that each array has a single writing process
  // Lanes with a clear enable keep their stored contents
  genvar g;
  generate
    for (g = 0; g < `QRS_BL; g = g + 1) begin : g_lane
      logic [`QRS_LW-1:0] lane_mem [0:(1<<`QRS_AW)-1];
      always_ff @(posedge clk) begin
        if (we && wlane[g]) begin
          lane_mem[waddr] <= wdata[g*`QRS_LW +: `QRS_LW];
        end
      end
      assign rdata[g*`QRS_LW +: `QRS_LW] = lane_mem[raddr];
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/qrs_port_logic.sv
// Read and write port logic of the burst static memory
`timescale 1ns/100ps
`default_nettype none
`include "qrs_defs.svh"
module qrs_port_logic
  import qrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic k_clk,
  input wire logic kn_clk,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [`QRS_AW-1:0] addr,
  input wire logic [`QRS_DW-1:0] wr_data,
  input wire logic [1:0] byte_lane_write_select_n,
  input wire logic loop_disable_n,
  output logic [`QRS_DW-1:0] rd_data,
  output logic rd_data_oe,
  output logic output_valid_flag,
  output logic echo_clock_out,
  output logic echo_clock_n_out,
  output logic dll_locked,
  output logic impedance_update
);
  // ==========================================================
  // System clock domain
  logic [`QRS_IMP_W-1:0] imp_cnt_q;
  logic imp_upd_q;
  logic hb_s;
  logic hb_prev_q;
  logic [`QRS_STOP_W-1:0] stop_cnt_q;
  logic clk_stop_q;
  wire imp_wrap = imp_cnt_q == `QRS_IMP_W'(`QRS_IMP_CYC - 1);
  wire hb_chg = hb_s ^ hb_prev_q;
  wire stop_full = stop_cnt_q >= `QRS_STOP_W'(`QRS_STOP_CYC + `QRS_STOP_GUARD);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      imp_cnt_q <= '0;
      imp_upd_q <= 1'b0;
    end else begin
      imp_cnt_q <= imp_cnt_q + `QRS_IMP_W'(1);
      imp_upd_q <= imp_wrap;
    end
  end

  // Missing heartbeat from the link side means the input clocks stopped
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hb_prev_q <= 1'b0;
      stop_cnt_q <= '0;
      clk_stop_q <= 1'b0;
    end else begin
      hb_prev_q <= hb_s;
      if (hb_chg) begin
        stop_cnt_q <= '0;
      end else if (!stop_full) begin
        stop_cnt_q <= stop_cnt_q + `QRS_STOP_W'(1);
      end
      clk_stop_q <= stop_full;
    end
  end

  // ==========================================================
  // Crossings
  logic rst_k_n;
  logic rst_kn_n;
  logic stop_k;
  logic dll_en_k;
  logic hb_q;
  qrs_sync2 u_sync_rk (.clk(k_clk), .d(reset_n), .q(rst_k_n));
  qrs_sync2 u_sync_rkn (.clk(kn_clk), .d(reset_n), .q(rst_kn_n));
  qrs_sync2 u_sync_stop (.clk(k_clk), .d(clk_stop_q), .q(stop_k));
  qrs_sync2 u_sync_loop_disable_n (.clk(k_clk), .d(loop_disable_n), .q(dll_en_k));
  qrs_sync2 u_sync_hb (.clk(clk_sys), .d(hb_q), .q(hb_s));

  // ==========================================================
  // Delay lock loop model
  logic [`QRS_LOCK_W-1:0] lock_cnt_q;
  logic locked_q;
  wire lock_last = lock_cnt_q == `QRS_LOCK_W'(`QRS_LOCK_CYC - 1);

  always_ff @(posedge k_clk) begin
    if (!rst_k_n || stop_k || !dll_en_k) begin
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
    end else if (lock_last) begin
      locked_q <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + `QRS_LOCK_W'(1);
    end
  end

  // Loop on gives two-cycle latency, off gives one
  wire lat2 = dll_en_k;

  // ==========================================================
  // Request acceptance and arbitration
  logic rp1_q;
  logic rp2_q;
  logic wp1_q;
  logic wp2_q;
  logic wp3_q;
  logic [`QRS_AW-1:0] ra_q;
  logic [`QRS_AW-1:0] wa_q;
  logic [`QRS_AW-1:0] wc_q;
  wire rd_req = ~read_port_select_n;
  wire wr_req = ~write_port_select_n;
  wire rd_go = rd_req && !rp1_q;
  wire wr_go = wr_req && !wp1_q && !rd_go;

  always_ff @(posedge k_clk) begin
    if (!rst_k_n) begin
      rp1_q <= 1'b0;
      rp2_q <= 1'b0;
      wp1_q <= 1'b0;
      wp2_q <= 1'b0;
      wp3_q <= 1'b0;
      hb_q <= 1'b0;
    end else begin
      rp1_q <= rd_go;
      rp2_q <= rp1_q;
      wp1_q <= wr_go;
      wp2_q <= wp1_q;
      wp3_q <= wp2_q;
      hb_q <= ~hb_q;
    end
  end

  always_ff @(posedge k_clk) begin
    if (rd_go) begin
      ra_q <= addr;
    end
    if (wr_go) begin
      wa_q <= addr;
    end
    if (wp2_q) begin
      wc_q <= wa_q;
    end
  end

  // ==========================================================
  // Write burst capture
  logic [`QRS_DW-1:0] kn_d_q;
  logic [1:0] kn_en_q;
  logic [3*`QRS_DW-1:0] wbuf_q;
  logic [5:0] wm_q;
  wire kn_cap = wp2_q || wp3_q;

  // Odd words arrive on negative clock rises
  always_ff @(posedge kn_clk) begin
    if (kn_cap) begin
      kn_d_q <= wr_data;
      kn_en_q <= ~byte_lane_write_select_n;
    end
  end

  always_ff @(posedge k_clk) begin
    if (wp1_q) begin
      wbuf_q[17:0] <= wr_data;
      wm_q[1:0] <= ~byte_lane_write_select_n;
    end
    if (wp2_q) begin
      wbuf_q[35:18] <= kn_d_q;
      wm_q[3:2] <= kn_en_q;
      wbuf_q[53:36] <= wr_data;
      wm_q[5:4] <= ~byte_lane_write_select_n;
    end
  end

  wire [`QRS_BW-1:0] cw = {kn_d_q, wbuf_q};
  wire [`QRS_BL-1:0] cm = {kn_en_q, wm_q};
  wire [`QRS_BW-1:0] mem_rd;

  // Whole burst commits at once; word n sits at lane pair n of location A
  qrs_mem_array u_mem (
    .clk(k_clk),
    .we(wp3_q),
    .waddr(wc_q),
    .wdata(cw),
    .wlane(cm),
    .raddr(ra_q),
    .rdata(mem_rd)
  );

  // ==========================================================
  // Read fetch with forwarding of the committing burst
  wire ld = lat2 ? rp2_q : rp1_q;
  wire fwd = wp3_q && (wc_q == ra_q);
  wire [`QRS_BW-1:0] rbur;
  genvar g;
  generate
    for (g = 0; g < `QRS_BL; g = g + 1) begin : g_fwd
      assign rbur[g*`QRS_LW +: `QRS_LW] = (fwd && cm[g]) ?
        cw[g*`QRS_LW +: `QRS_LW] : mem_rd[g*`QRS_LW +: `QRS_LW];
    end
  endgenerate

  // ==========================================================
  // Read output sequencing
  qrs_out_type out_q;
  logic [`QRS_BW-1:0] burst_q;
  logic [`QRS_DW-1:0] k_word_q;
  logic k_oe_q;
  logic k_vld_q;
  logic k_tog_q;
  wire out_first = out_q == QRS_OUT_FIRST;
  wire out_second = out_q == QRS_OUT_SECOND;

  always_ff @(posedge k_clk) begin
    if (!rst_k_n) begin
      out_q <= QRS_OUT_IDLE;
      k_oe_q <= 1'b0;
      k_vld_q <= 1'b0;
      k_tog_q <= 1'b0;
    end else begin
      k_tog_q <= ~k_tog_q;
      k_oe_q <= ld || out_first;
      k_vld_q <= ld || out_first;
      unique case (out_q)
        QRS_OUT_IDLE: begin
          out_q <= ld ? QRS_OUT_FIRST : QRS_OUT_IDLE;
        end
        QRS_OUT_FIRST: begin
          out_q <= QRS_OUT_SECOND;
        end
        QRS_OUT_SECOND: begin
          out_q <= ld ? QRS_OUT_FIRST : QRS_OUT_IDLE;
        end
        default: begin
          out_q <= QRS_OUT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge k_clk) begin
    if (ld) begin
      burst_q <= rbur;
      k_word_q <= rbur[17:0];
    end else if (out_first) begin
      k_word_q <= burst_q[53:36];
    end
  end

  // Negative half: odd words, and the flag half a cycle early
  logic [`QRS_DW-1:0] kn_word_q;
  logic kn_oe_q;
  logic kn_vld_q;
  logic kn_tog_q;

  always_ff @(posedge kn_clk) begin
    if (!rst_kn_n) begin
      kn_oe_q <= 1'b0;
      kn_vld_q <= 1'b0;
      kn_tog_q <= 1'b0;
    end else begin
      kn_tog_q <= k_tog_q;
      kn_oe_q <= out_first || out_second;
      kn_vld_q <= ld || out_first;
      kn_word_q <= out_first ? burst_q[35:18] : burst_q[71:54];
    end
  end

  // ==========================================================
  // Pins: phase is high in the positive half of the input clock
  wire ph = k_tog_q ^ kn_tog_q;
  assign echo_clock_out = ph;
  assign echo_clock_n_out = ~ph;
  assign rd_data = ph ? k_word_q : kn_word_q;
  assign rd_data_oe = ph ? k_oe_q : kn_oe_q;
  assign output_valid_flag = ph ? k_vld_q : kn_vld_q;
  assign dll_locked = locked_q;
  assign impedance_update = imp_upd_q;

  // ==========================================================
  // Checks
  no_back_rd_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    rp1_q |-> !rd_go) else $error("read started on consecutive rises");
  rd_first_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    (rd_req && wr_req && !rp1_q && !wp1_q) |-> (rd_go && !wr_go))
    else $error("read not first from idle");
  wr_after_rd_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    (rp1_q && wr_req && !wp1_q) |-> wr_go) else $error("write lost after read");
  rd_after_wr_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    (wp1_q && rd_req && !rp1_q) |-> rd_go) else $error("read lost after write");
  wr_commit_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    wr_go |-> ##3 (wp3_q && wc_q == $past(addr, 3)))
    else $error("write burst not committed at t+3");
  rd_lat_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    (rd_go && lat2 && $past(lat2)) |-> ##3 (out_first && k_oe_q && k_vld_q))
    else $error("read data not out at t+2");
  fwd_data_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    (ld && fwd && cm[0]) |=> burst_q[8:0] == $past(wbuf_q[8:0]))
    else $error("newest write not forwarded");
  quiet_out_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    (!ld && !out_first) |=> !k_oe_q) else $error("read outputs driven while idle");
  lock_time_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    $rose(locked_q) |-> $past(lock_cnt_q) == `QRS_LOCK_W'(`QRS_LOCK_CYC - 1))
    else $error("lock reported early");
  imp_gap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    imp_upd_q |=> (!imp_upd_q) [*8]) else $error("impedance update too frequent");
  no_back_wr_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    wp1_q |-> !wr_go)
    else $error("write started on consecutive rises");
  kn_quiet_a: assert property (@(posedge kn_clk) disable iff (!rst_kn_n)
    (!out_first && !out_second) |=> !kn_oe_q)
    else $error("odd word outputs driven while idle");
  imp_period_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    imp_upd_q |-> imp_cnt_q == `QRS_IMP_W'(0))
    else $error("impedance update off its period");
  flag_early_a: assert property (@(posedge kn_clk) disable iff (!rst_kn_n)
    ld |=> kn_vld_q)
    else $error("valid flag not raised half a cycle early");
  lock_drop_a: assert property (@(posedge k_clk) disable iff (!rst_k_n)
    !dll_en_k |=> !locked_q)
    else $error("lock kept with loop disabled");
  odd_word_a: assert property (@(posedge kn_clk) disable iff (!rst_kn_n)
    out_first |=> kn_word_q == $past(burst_q[35:18]))
    else $error("second burst word not driven");
endmodule
`default_nettype wire

//--- test/qrs_ctrl_model.sv
// Memory controller model on the link side of the port logic
`timescale 1ns/100ps
`default_nettype none
`include "qrs_defs.svh"
module qrs_ctrl_model (
  output logic k_clk,
  output logic kn_clk,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [`QRS_AW-1:0] addr,
  output logic [`QRS_DW-1:0] wr_data,
  output logic [1:0] byte_lane_write_select_n,
  input wire logic [`QRS_DW-1:0] rd_data,
  input wire logic rd_data_oe,
  input wire logic output_valid_flag
);
  logic run = 1'b1;
  assign kn_clk = ~k_clk;
  initial begin
    k_clk = 1'b0;
    {read_port_select_n, write_port_select_n} = 2'h3;
    addr = 19'h0;
    wr_data = 18'h0;
    byte_lane_write_select_n = 2'h3;
    forever #7.5 if (run) k_clk = ~k_clk;
  end
  // Clock stops with K low just after a fall
  task automatic halt(input int ns);
    @(negedge k_clk);
    run = 1'b0;
    #(ns);
    run = 1'b1;
  endtask
  task automatic wr(input logic [`QRS_AW-1:0] a, input logic [71:0] d, input logic [7:0] l, input int hold);
    @(posedge k_clk) #3;
    write_port_select_n = 1'b0;
    addr = a;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) @(posedge kn_clk) #2;
      else @(posedge k_clk) #2;
      if (i == hold - 1) write_port_select_n = 1'b1;
      if (i == 0) addr = ~a;
      wr_data = d[18*i +: 18];
      byte_lane_write_select_n = l[2*i +: 2];
    end
    @(posedge kn_clk) #2;
    wr_data = ~wr_data;
    byte_lane_write_select_n = ~byte_lane_write_select_n;
  endtask
  task automatic rd(input logic [`QRS_AW-1:0] a, input int lat, input int hold, output logic [71:0] q,
                    output logic [5:0] st);
    @(posedge k_clk) #3;
    read_port_select_n = 1'b0;
    addr = a;
    @(posedge k_clk) #2;
    if (hold == 1) read_port_select_n = 1'b1;
    addr = ~a;
    if (lat == 2) begin
      @(posedge k_clk) #2;
      read_port_select_n = 1'b1;
    end
    @(posedge kn_clk) #3;
    st[5] = output_valid_flag;
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) @(posedge k_clk) #3;
      else @(posedge kn_clk) #3;
      q[18*i +: 18] = rd_data;
      st[4-i] = rd_data_oe;
    end
    @(posedge k_clk) #3;
    st[0] = rd_data_oe;
  endtask
endmodule
`default_nettype wire

//--- test/test_quad_rate_sram_port_logic.sv
// Self-checking bench for the burst memory port logic
`timescale 1ns/100ps
`default_nettype none
`include "qrs_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_quad_rate_sram_port_logic;
  logic clk_sys, reset_n, loop_disable_n, k_clk, kn_clk, read_port_select_n, write_port_select_n;
  logic rd_data_oe, output_valid_flag, echo_clock_out, echo_clock_n_out, dll_locked, impedance_update;
  logic [`QRS_AW-1:0] addr;
  logic [`QRS_DW-1:0] wr_data, rd_data;
  logic [1:0] byte_lane_write_select_n;
  logic [71:0] mem [logic [`QRS_AW-1:0]];
  int fails = 0;
  int num_checks = 0;
  int seed = 32'h44b7a0bc;
  qrs_port_logic dut (.clk_sys, .reset_n, .k_clk, .kn_clk, .read_port_select_n, .write_port_select_n, .addr,
    .wr_data, .byte_lane_write_select_n, .loop_disable_n, .rd_data, .rd_data_oe, .output_valid_flag,
    .echo_clock_out, .echo_clock_n_out, .dll_locked, .impedance_update);
  qrs_ctrl_model ctrl (.k_clk, .kn_clk, .read_port_select_n, .write_port_select_n, .addr, .wr_data,
    .byte_lane_write_select_n, .rd_data, .rd_data_oe, .output_valid_flag);
  function automatic logic [71:0] merge(input logic [71:0] o, input logic [71:0] n, input logic [7:0] l);
    for (int j = 0; j < 8; j++) begin
      if (!l[j]) o[9*j +: 9] = n[9*j +: 9];
    end
    return o;
  endfunction
  task automatic rchk(input logic [`QRS_AW-1:0] a, input logic [71:0] e, input int lat, input int hold);
    logic [71:0] q;
    logic [5:0] st;
    ctrl.rd(a, lat, hold, q, st);
    `CHK(q, e)
    `CHK(st, 6'h3e)
  endtask
  task automatic wput(input logic [`QRS_AW-1:0] a, input logic [71:0] d, input logic [7:0] l, input int hold);
    mem[a] = merge(mem[a], d, l);
    ctrl.wr(a, d, l, hold);
  endtask
  task automatic stop_test;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  initial begin
    logic [95:0] r;
    logic [`QRS_AW-1:0] a, b;
    logic [71:0] e;
    int n;
    reset_n = 1'b0;
    loop_disable_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK({rd_data_oe, output_valid_flag, dll_locked}, 3'h0)
    reset_n = 1'b1;
    repeat (2040) @(posedge k_clk);
    #3;
    `CHK(dll_locked, 1'b0)
    repeat (40) @(posedge k_clk);
    #3;
    `CHK(dll_locked, 1'b1)
    for (int i = 0; i < 4; i++) begin
      @(posedge k_clk) #3;
      `CHK({echo_clock_out, echo_clock_n_out}, 2'h2)
      @(posedge kn_clk) #3;
      `CHK({echo_clock_out, echo_clock_n_out}, 2'h1)
    end
    for (int i = 0; i < 8; i++) begin
      r = {$random(seed), $random(seed), $random(seed)};
      a = r[90:72];
      wput(a, r[71:0], 8'h00, 1);
      r = {$random(seed), $random(seed), $random(seed)};
      wput(a, r[71:0], (i == 0) ? 8'hff : r[79:72], 1 + i % 2);
      rchk(a, mem[a], 2, 1);
    end
    // Write then read of the same place on the next rise
    r = {$random(seed), $random(seed), $random(seed)};
    e = merge(mem[a], r[71:0], r[95:88]);
    fork
      wput(a, r[71:0], r[95:88], 2);
      begin
        @(posedge k_clk);
        rchk(a, e, 2, 1);
      end
    join
    e = mem[a];
    fork
      ctrl.wr(a, ~e, 8'h00, 1);
      rchk(a, e, 2, 1);
    join
    rchk(a, e, 2, 1);
    r = {$random(seed), $random(seed), $random(seed)};
    b = a + 19'h1;
    fork
      rchk(a, e, 2, 2);
      begin
        @(posedge k_clk);
        wput(b, r[71:0], 8'h00, 1);
      end
    join
    rchk(b, mem[b], 2, 1);
    ctrl.halt(303);
    repeat (4) @(posedge k_clk);
    #3;
    `CHK(dll_locked, 1'b0)
    rchk(a, mem[a], 2, 1);
    @(negedge clk_sys) loop_disable_n = 1'b0;
    repeat (8) @(posedge k_clk);
    rchk(b, mem[b], 1, 1);
    @(negedge clk_sys) loop_disable_n = 1'b1;
    n = 0;
    while (impedance_update !== 1'b1 && n < 1100) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (impedance_update !== 1'b1 && n < 1100);
    `CHK(n, 1024)
    stop_test();
  end
endmodule
`default_nettype wire
